/* File: rtl/dpl_regulator.sv */
/*
 * Digital control core of one step-down regulator: duty limit, PID loop,
 * system identification, active current share and telemetry.
 * Assumes the manager pulses sw_tick once per switching period and that
 * ADC samples arrive synchronous to core_clk.
 */
// Overview of operation
// - duty never exceeds writable duty limit
// - PID with four separately written coefficients
// - system_identification injects PRBS, captures output voltage
// - host loads sane coefficients before system_identification
// - share low time tracks own load current
// - wider observed share duty raises target
// - load regulation droops target, retards share
// - larger regulation setting, larger droop
// - followers get regulation two-three steps higher
// - manager assigns one of ten share buses
// - telemetry 12-bit voltage, 8-bit current, temperature
// - current reading corrected by temperature
// - manager refreshes telemetry every second
`include "dpl_map.svh"
`timescale 1ns/100ps
`default_nettype none

module dpl_regulator
	import dpl_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	dpl_link_if.regulator link,
	input wire logic [11:0] adc_vout,
	input wire logic [7:0] adc_iout,
	input wire logic [7:0] adc_temp,
	output logic [7:0] pwm_duty,
	output logic system_identification_active
);

	// ==========================================================
	// helpers
	function automatic logic [7:0] sat_u8(input dpl_acc_type v);
		if (v < 25'sd0) begin
			return 8'h00;
		end
		if (v > 25'sd255) begin
			return 8'hff;
		end
		return v[7:0];
	endfunction

	// ==========================================================
	// registers
	logic [7:0] duty_limit_setting_r;
	logic [7:0] proportional_coeff_r;
	logic [7:0] integral_coeff_r;
	logic [7:0] derivative_coeff_r;
	logic [3:0] derivative_rolloff_coeff_r;
	logic [3:0] load_reg_r;
	logic [11:0] vtarget_r;
	logic system_identification_r;
	logic [11:0] vout_r;
	logic [7:0] iout_r;
	logic [7:0] temp_r;
	logic [15:0] cap_mem [`DPL_CAP_DEPTH];
	logic [2:0] cap_idx_r;
	logic rvalid_r;
	logic [15:0] rdata_r;
	logic [4:0] phase_r;
	logic [4:0] own_low_r;
	logic [4:0] obs_low_r;
	logic signed [5:0] trim_r;
	logic share_oe_r;
	dpl_acc_type integ_r;
	dpl_acc_type dfilt_r;
	dpl_err_type err_prev_r;
	logic [7:0] duty_r;

	// ==========================================================
	// configuration port
	wire cfg_wr = link.cfg_valid & link.cfg_write;
	wire cfg_rd = link.cfg_valid & ~link.cfg_write;
	logic [15:0] rd_mux;

	assign link.cfg_ready = 1'b1;
	assign link.cfg_rvalid = rvalid_r;
	assign link.cfg_rdata = rdata_r;

	always_comb begin
		rd_mux = 16'h0000;
		if (link.cfg_addr[`DPL_DEV_CAP_BIT]) begin
			rd_mux = cap_mem[link.cfg_addr[2:0]];
		end else begin
			unique case (link.cfg_addr)
				`DPL_DEV_DUTY_LIM: rd_mux = {8'h00, duty_limit_setting_r};
				`DPL_DEV_KP: rd_mux = {8'h00, proportional_coeff_r};
				`DPL_DEV_KI: rd_mux = {8'h00, integral_coeff_r};
				`DPL_DEV_KD: rd_mux = {8'h00, derivative_coeff_r};
				`DPL_DEV_ROLLOFF: rd_mux = {12'h000, derivative_rolloff_coeff_r};
				`DPL_DEV_LOADREG: rd_mux = {12'h000, load_reg_r};
				`DPL_DEV_VTARGET: rd_mux = {4'h0, vtarget_r};
				`DPL_DEV_SYSTEM_IDENTIFICATION: rd_mux = {15'h0000, system_identification_r};
				`DPL_DEV_VOUT: rd_mux = {4'h0, vout_r};
				`DPL_DEV_IOUT: rd_mux = {8'h00, iout_r};
				`DPL_DEV_TEMP: rd_mux = {8'h00, temp_r};
				`DPL_DEV_TRIM: rd_mux = {{10{trim_r[5]}}, trim_r};
				default: rd_mux = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			duty_limit_setting_r <= `DPL_DUTY_LIM_RST;
			proportional_coeff_r <= `DPL_KP_RST;
			integral_coeff_r <= `DPL_KI_RST;
			derivative_coeff_r <= `DPL_KD_RST;
			derivative_rolloff_coeff_r <= `DPL_ROLLOFF_RST;
			load_reg_r <= 4'h0;
			vtarget_r <= `DPL_VTARGET_RST;
			system_identification_r <= 1'b0;
		end else if (cfg_wr) begin
			unique case (link.cfg_addr)
				`DPL_DEV_DUTY_LIM: duty_limit_setting_r <= link.cfg_wdata[7:0];
				`DPL_DEV_KP: proportional_coeff_r <= link.cfg_wdata[7:0];
				`DPL_DEV_KI: integral_coeff_r <= link.cfg_wdata[7:0];
				`DPL_DEV_KD: derivative_coeff_r <= link.cfg_wdata[7:0];
				`DPL_DEV_ROLLOFF: derivative_rolloff_coeff_r <= link.cfg_wdata[3:0];
				`DPL_DEV_LOADREG: load_reg_r <= link.cfg_wdata[3:0];
				`DPL_DEV_VTARGET: vtarget_r <= link.cfg_wdata[11:0];
				`DPL_DEV_SYSTEM_IDENTIFICATION: system_identification_r <= link.cfg_wdata[0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rvalid_r <= 1'b0;
			rdata_r <= 16'h0000;
		end else begin
			rvalid_r <= cfg_rd;
			rdata_r <= cfg_rd ? rd_mux : rdata_r;
		end
	end

	// ==========================================================
	// telemetry: current corrected for inductor resistance drift
	wire signed [8:0] temp_delta = $signed({1'b0, adc_temp}) - $signed({1'b0, `DPL_TEMP_REF});
	wire dpl_acc_type iout_adj = 25'($signed({1'b0, adc_iout}) * temp_delta) >>> 8;
	wire dpl_acc_type iout_corr = 25'($signed({1'b0, adc_iout})) - iout_adj;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			vout_r <= 12'h000;
			iout_r <= 8'h00;
			temp_r <= 8'h00;
		end else begin
			vout_r <= adc_vout;
			iout_r <= sat_u8(iout_corr);
			temp_r <= adc_temp;
		end
	end

	// ==========================================================
	// current share line
	wire tick = link.sw_tick;
	wire [12:0] own_raw = (13'(iout_r) * 13'(`DPL_SW_PERIOD)) >> 8;
	wire [4:0] own_low_nxt = (own_raw[4:0] > 5'(load_reg_r)) ? own_raw[4:0] - 5'(load_reg_r) : 5'h00;
	wire [4:0] phase_nxt = tick ? 5'h00 : phase_r + 5'h01;
	wire share_gt = obs_low_r > own_low_r;
	wire share_lt = obs_low_r < own_low_r;

	assign link.share_out = 1'b0;
	assign link.share_oe = share_oe_r;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_r <= 5'h00;
			own_low_r <= 5'h00;
			obs_low_r <= 5'h00;
			trim_r <= 6'sd0;
			share_oe_r <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			share_oe_r <= phase_nxt < (tick ? own_low_nxt : own_low_r);
			if (tick) begin
				own_low_r <= own_low_nxt;
				obs_low_r <= 5'h00;
				if (share_gt && trim_r < `DPL_TRIM_MAX) begin
					trim_r <= trim_r + 6'sd1;
				end else if (share_lt && trim_r > `DPL_TRIM_MIN) begin
					trim_r <= trim_r - 6'sd1;
				end
			end else if (!link.share_in) begin
				obs_low_r <= obs_low_r + 5'h01;
			end
		end
	end

	// ==========================================================
	// PID compensator, updated once per switching period
	logic prbs_bit;

	dpl_prbs u_prbs (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.step(tick & system_identification_r),
		.bit_out(prbs_bit)
	);

	wire [11:0] droop = (12'(load_reg_r) * 12'(iout_r)) >> 4;
	wire dpl_err_type target = 14'(vtarget_r) + 14'(trim_r) - 14'(droop);
	wire dpl_err_type err = target - $signed({2'b00, vout_r});
	wire dpl_err_type delta = err - err_prev_r;
	wire dpl_acc_type p_term = 25'($signed({1'b0, proportional_coeff_r}) * err);
	wire dpl_acc_type i_step = 25'($signed({1'b0, integral_coeff_r}) * err);
	wire dpl_acc_type d_raw = 25'($signed({1'b0, derivative_coeff_r}) * delta);
	wire dpl_acc_type d_nxt = dfilt_r + ((d_raw - dfilt_r) >>> derivative_rolloff_coeff_r);
	wire dpl_acc_type inject = system_identification_r ? (prbs_bit ? `DPL_PRBS_AMP : -`DPL_PRBS_AMP) : 25'sd0;
	wire dpl_acc_type pid_sum = ((p_term + integ_r + d_nxt) >>> `DPL_PID_SHIFT) + inject;
	wire [7:0] duty_raw = sat_u8(pid_sum);
	wire clamped = duty_raw > duty_limit_setting_r;
	wire [7:0] duty_nxt = clamped ? duty_limit_setting_r : duty_raw;

	assign pwm_duty = duty_r;
	assign system_identification_active = system_identification_r;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			integ_r <= 25'sd0;
			dfilt_r <= 25'sd0;
			err_prev_r <= 14'sd0;
			duty_r <= 8'h00;
			cap_idx_r <= 3'h0;
		end else if (tick) begin
			// integrator holds while clamped so it does not wind up
			integ_r <= clamped ? integ_r : integ_r + i_step;
			dfilt_r <= d_nxt;
			err_prev_r <= err;
			duty_r <= duty_nxt;
			cap_idx_r <= system_identification_r ? cap_idx_r + 3'h1 : 3'h0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (tick && system_identification_r) begin
			cap_mem[cap_idx_r] <= {prbs_bit, 3'h0, vout_r};
		end
	end
endmodule

`default_nettype wire

/* File: common/dpl_map.svh */
/*
 * Offsets, field positions, reset values and timing counts shared by the
 * regulator, the power manager and their link.
 * Assumes a 10 MHz core clock common to both ends.
 */
`ifndef DPL_MAP_SVH
`define DPL_MAP_SVH

// ==========================================================
// timing
`define DPL_CLK_HZ 10000000
`define DPL_SW_KHZ 500
`define DPL_SW_PERIOD (`DPL_CLK_HZ / 1000 / `DPL_SW_KHZ)
`define DPL_REFRESH_MS 1000
`define DPL_REFRESH_CYCLES (`DPL_REFRESH_MS * (`DPL_CLK_HZ / 1000))

// ==========================================================
// regulator register indices on the link
`define DPL_DEV_DUTY_LIM 5'h00
`define DPL_DEV_KP 5'h01
`define DPL_DEV_KI 5'h02
`define DPL_DEV_KD 5'h03
`define DPL_DEV_ROLLOFF 5'h04
`define DPL_DEV_LOADREG 5'h05
`define DPL_DEV_VTARGET 5'h06
`define DPL_DEV_SYSTEM_IDENTIFICATION 5'h07
`define DPL_DEV_VOUT 5'h08
`define DPL_DEV_IOUT 5'h09
`define DPL_DEV_TEMP 5'h0a
`define DPL_DEV_TRIM 5'h0b
`define DPL_DEV_CAP_BIT 4
`define DPL_CAP_DEPTH 8

// ==========================================================
// regulator reset values and loop constants
`define DPL_DUTY_LIM_RST 8'h80
`define DPL_KP_RST 8'h10
`define DPL_KI_RST 8'h02
`define DPL_KD_RST 8'h00
`define DPL_ROLLOFF_RST 4'h2
`define DPL_VTARGET_RST 12'h400
`define DPL_TEMP_REF 8'h40
`define DPL_PID_SHIFT 6
`define DPL_PRBS_AMP 25'sd8
`define DPL_TRIM_MAX 6'sd31
`define DPL_TRIM_MIN (-6'sd31)

// ==========================================================
// manager AXI4-Lite byte offsets
`define DPL_AXI_CMD 8'h00
`define DPL_AXI_STATUS 8'h04
`define DPL_AXI_TEL_V 8'h08
`define DPL_AXI_TEL_I 8'h0c
`define DPL_AXI_TEL_T 8'h10
`define DPL_AXI_SHARE_BUS 8'h14
`define DPL_CMD_READ_BIT 24
`define DPL_CMD_ADDR_LSB 16
`define DPL_SHARE_BUS_MAX 4'h9
`define DPL_RESP_OKAY 2'b00
`define DPL_RESP_SLVERR 2'b10

`endif

/* File: common/dpl_pkg.sv */
/*
 * Types shared by the regulator and power manager ends.
 * Assumes dpl_map.svh supplies the numeric constants.
 */
package dpl_pkg;

	// ==========================================================
	// manager link sequencer
	typedef enum logic [1:0] {
		DPL_MGR_IDLE = 2'b00,
		DPL_MGR_WAIT = 2'b01
	} dpl_mgr_state_type;

	typedef logic signed [24:0] dpl_acc_type;
	typedef logic signed [13:0] dpl_err_type;

endpackage

/* File: common/dpl_link_if.sv */
/*
 * Link between one regulator and the power manager: switching tick,
 * configuration port and the open-drain current share line.
 * Assumes the bench drives peer_share_low for other regulators.
 */
`timescale 1ns/100ps
`default_nettype none

interface dpl_link_if (
	input wire logic core_clk
);
	logic sw_tick;
	logic cfg_valid;
	logic cfg_write;
	logic [4:0] cfg_addr;
	logic [15:0] cfg_wdata;
	logic cfg_ready;
	logic cfg_rvalid;
	logic [15:0] cfg_rdata;
	logic share_out;
	logic share_oe;
	logic share_in;
	logic peer_share_low;

	// wired-and share line: low while any party pulls it
	assign share_in = ~((share_oe & ~share_out) | peer_share_low);

	modport regulator (
		input sw_tick, cfg_valid, cfg_write, cfg_addr, cfg_wdata, share_in,
		output cfg_ready, cfg_rvalid, cfg_rdata, share_out, share_oe
	);
	modport manager (
		output sw_tick, cfg_valid, cfg_write, cfg_addr, cfg_wdata,
		input cfg_ready, cfg_rvalid, cfg_rdata
	);
endinterface

`default_nettype wire

/* File: rtl/dpl_prbs.sv */
/*
 * Seven-bit maximal-length pseudo-random bit source.
 * Assumes step is a one-cycle pulse; holds its sequence otherwise.
 */
`timescale 1ns/100ps
`default_nettype none

module dpl_prbs (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic step,
	output logic bit_out
);
	logic [6:0] lfsr_r;
	logic [6:0] lfsr_nxt;

	assign lfsr_nxt = {lfsr_r[5:0], lfsr_r[6] ^ lfsr_r[5]};
	assign bit_out = lfsr_r[6];

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			lfsr_r <= 7'h7f;
		end else if (step) begin
			lfsr_r <= lfsr_nxt;
		end
	end
endmodule

`default_nettype wire

/* File: rtl/dpl_manager.sv */
/*
 * Power manager end: AXI4-Lite register slave, switching tick source,
 * command forwarding and periodic telemetry refresh of one regulator.
 * Assumes a single AXI4-Lite master and the regulator on the link.
 */
`include "dpl_map.svh"
`timescale 1ns/100ps
`default_nettype none

module dpl_manager
	import dpl_pkg::*;
#(
	parameter int REFRESH_CYCLES = `DPL_REFRESH_CYCLES
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	dpl_link_if.manager link,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ==========================================================
	// switching tick
	logic [4:0] sw_cnt_r;
	wire sw_wrap = sw_cnt_r == 5'(`DPL_SW_PERIOD - 1);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sw_cnt_r <= 5'h00;
			link.sw_tick <= 1'b0;
		end else begin
			sw_cnt_r <= sw_wrap ? 5'h00 : sw_cnt_r + 5'h01;
			link.sw_tick <= sw_wrap;
		end
	end

	// ==========================================================
	// AXI4-Lite slave
	logic [24:0] cmd_r;
	logic cmd_pend_r;
	logic [15:0] last_rd_r;
	logic [11:0] tel_v_r;
	logic [7:0] tel_i_r;
	logic [7:0] tel_t_r;
	logic [3:0] share_bus_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic rvalid_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	dpl_mgr_state_type state_r;

	wire wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
	wire rd_go = s_axi_arvalid & ~rvalid_r;
	wire wr_cmd = wr_go && s_axi_awaddr == `DPL_AXI_CMD && !cmd_pend_r;
	wire wr_bus = wr_go && s_axi_awaddr == `DPL_AXI_SHARE_BUS;
	wire wr_ok = wr_cmd | wr_bus;
	wire busy = cmd_pend_r | link.cfg_valid | (state_r != DPL_MGR_IDLE);
	logic [31:0] rd_mux;
	logic rd_hit;

	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = rd_go;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			`DPL_AXI_CMD: rd_mux = {7'h00, cmd_r};
			`DPL_AXI_STATUS: rd_mux = {15'h0000, busy, last_rd_r};
			`DPL_AXI_TEL_V: rd_mux = {20'h00000, tel_v_r};
			`DPL_AXI_TEL_I: rd_mux = {24'h000000, tel_i_r};
			`DPL_AXI_TEL_T: rd_mux = {24'h000000, tel_t_r};
			`DPL_AXI_SHARE_BUS: rd_mux = {28'h0000000, share_bus_r};
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			bvalid_r <= 1'b0;
			bresp_r <= `DPL_RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `DPL_RESP_OKAY;
			share_bus_r <= 4'h0;
		end else begin
			if (wr_go) begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_ok ? `DPL_RESP_OKAY : `DPL_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
			if (rd_go) begin
				rvalid_r <= 1'b1;
				rdata_r <= rd_mux;
				rresp_r <= rd_hit ? `DPL_RESP_OKAY : `DPL_RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
			// bus number is bookkeeping only; values above nine are refused
			if (wr_bus && s_axi_wdata[3:0] <= `DPL_SHARE_BUS_MAX && s_axi_wstrb[0]) begin
				share_bus_r <= s_axi_wdata[3:0];
			end
		end
	end

	// ==========================================================
	// link sequencer: host commands first, then telemetry refresh
	logic [31:0] refresh_cnt_r;
	logic [1:0] tel_idx_r;
	logic tel_run_r;
	logic cur_tel_r;

	wire refresh_wrap = refresh_cnt_r == 32'(REFRESH_CYCLES - 1);
	wire issue_cmd = state_r == DPL_MGR_IDLE && !link.cfg_valid && cmd_pend_r;
	wire issue_tel = state_r == DPL_MGR_IDLE && !link.cfg_valid && !cmd_pend_r && tel_run_r;
	wire taken = link.cfg_valid & link.cfg_ready;
	wire [4:0] tel_addr = `DPL_DEV_VOUT + 5'(tel_idx_r);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			refresh_cnt_r <= 32'h0000_0000;
			cmd_r <= 25'h0000000;
			cmd_pend_r <= 1'b0;
		end else begin
			refresh_cnt_r <= refresh_wrap ? 32'h0000_0000 : refresh_cnt_r + 32'h1;
			if (wr_cmd && s_axi_wstrb != 4'h0) begin
				cmd_r <= s_axi_wdata[24:0];
				cmd_pend_r <= 1'b1;
			end else if (issue_cmd) begin
				cmd_pend_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= DPL_MGR_IDLE;
			link.cfg_valid <= 1'b0;
			link.cfg_write <= 1'b0;
			link.cfg_addr <= 5'h00;
			link.cfg_wdata <= 16'h0000;
			tel_idx_r <= 2'h0;
			tel_run_r <= 1'b0;
			cur_tel_r <= 1'b0;
			last_rd_r <= 16'h0000;
			tel_v_r <= 12'h000;
			tel_i_r <= 8'h00;
			tel_t_r <= 8'h00;
		end else begin
			if (refresh_wrap && !tel_run_r) begin
				tel_run_r <= 1'b1;
				tel_idx_r <= 2'h0;
			end
			if (issue_cmd) begin
				link.cfg_valid <= 1'b1;
				link.cfg_write <= ~cmd_r[`DPL_CMD_READ_BIT];
				link.cfg_addr <= cmd_r[`DPL_CMD_ADDR_LSB +: 5];
				link.cfg_wdata <= cmd_r[15:0];
				cur_tel_r <= 1'b0;
			end else if (issue_tel) begin
				link.cfg_valid <= 1'b1;
				link.cfg_write <= 1'b0;
				link.cfg_addr <= tel_addr;
				cur_tel_r <= 1'b1;
			end else if (taken) begin
				link.cfg_valid <= 1'b0;
				state_r <= link.cfg_write ? DPL_MGR_IDLE : DPL_MGR_WAIT;
			end
			if (state_r == DPL_MGR_WAIT && link.cfg_rvalid) begin
				state_r <= DPL_MGR_IDLE;
				if (cur_tel_r) begin
					unique case (tel_idx_r)
						2'h0: tel_v_r <= link.cfg_rdata[11:0];
						2'h1: tel_i_r <= link.cfg_rdata[7:0];
						default: tel_t_r <= link.cfg_rdata[7:0];
					endcase
					tel_idx_r <= tel_idx_r + 2'h1;
					tel_run_r <= tel_idx_r != 2'h2;
				end else begin
					last_rd_r <= link.cfg_rdata;
				end
			end
		end
	end
endmodule

`default_nettype wire

/* File: test/dpl_link_sva.sv */
/*
 * Checker for the regulator to manager link.
 * Assumes the bench instantiates it beside the link interface.
 */
`timescale 1ns/100ps
`default_nettype none

module dpl_link_sva #(
	parameter int REFRESH_CYCLES = 200
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic sw_tick,
	input wire logic cfg_valid,
	input wire logic cfg_write,
	input wire logic [4:0] cfg_addr,
	input wire logic cfg_rvalid,
	input wire logic [15:0] cfg_rdata,
	input wire logic share_out,
	input wire logic share_oe,
	input wire logic peer_share_low
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	// ==========================================================
	// helper counters
	logic [5:0] low_cnt_r;
	logic [31:0] gap_r;
	wire logic refresh_rd = cfg_valid && !cfg_write && cfg_addr == 5'h08;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			low_cnt_r <= 6'h00;
			gap_r <= 32'h0;
		end else begin
			low_cnt_r <= share_oe ? low_cnt_r + 6'h01 : 6'h00;
			gap_r <= refresh_rd ? 32'h0 : gap_r + 32'h1;
		end
	end

	// ==========================================================
	// properties
	property p_tick_period;
		sw_tick |=> (!sw_tick)[*8] ##12 sw_tick;
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("switching tick period wrong");
	property p_read_answer;
		cfg_valid && !cfg_write |=> cfg_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("link read not answered");
	property p_rvalid_cause;
		cfg_rvalid |-> $past(cfg_valid && !cfg_write);
	endproperty
	a_rvalid_cause: assert property (p_rvalid_cause) else $error("read data without read");
	property p_rdata_hold;
		!cfg_rvalid |-> $stable(cfg_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved idle");
	property p_vout_width;
		cfg_rvalid && $past(cfg_addr) == 5'h08 |-> cfg_rdata[15:12] == 4'h0;
	endproperty
	a_vout_width: assert property (p_vout_width) else $error("voltage wider than 12 bits");
	property p_byte_width;
		cfg_rvalid && ($past(cfg_addr) == 5'h09 || $past(cfg_addr) == 5'h0a)
			|-> cfg_rdata[15:8] == 8'h00;
	endproperty
	a_byte_width: assert property (p_byte_width) else $error("current or temp too wide");
	property p_open_drain;
		share_oe |-> !share_out;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("share line driven high");
	property p_share_len;
		low_cnt_r <= 6'd19;
	endproperty
	a_share_len: assert property (p_share_len) else $error("share low spans period");
	property p_refresh_order;
		refresh_rd |-> ##[1:60] (cfg_valid && !cfg_write && cfg_addr == 5'h09);
	endproperty
	a_refresh_order: assert property (p_refresh_order) else $error("current not read after v");
	property p_refresh_gap;
		gap_r <= REFRESH_CYCLES + 64;
	endproperty
	a_refresh_gap: assert property (p_refresh_gap) else $error("telemetry refresh late");

	c_system_identification_on: cover property (cfg_valid && cfg_write && cfg_addr == 5'h07);
	c_share_both: cover property (share_oe && peer_share_low);
	c_capture: cover property (cfg_rvalid && $past(cfg_addr) == 5'h10);
endmodule

`default_nettype wire

/* File: test/tb_top.sv */
/*
 * Bench joining manager and regulator over the link, with AXI4-Lite tasks
 * and a queued read scoreboard.
 * Assumes a 10 MHz clock and a shortened telemetry refresh.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_top
	import dpl_pkg::*;
;
	localparam int REFRESH = 200;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	logic [11:0] adc_vout = 12'h400;
	logic [7:0] adc_iout = 8'h40, adc_temp = 8'h40, lim;
	wire logic [7:0] pwm_duty;
	wire logic system_identification_active;
	int err_count = 0, total_checks = 0, seed = 91, cnt;
	logic [31:0] q_data[$], q_mask[$], got, m, sm;
	logic [1:0] q_resp[$], q_bresp[$];
	logic [15:0] rst_tab[8] = '{16'h80, 16'h10, 16'h2, 16'h0, 16'h2, 16'h0, 16'h400, 16'h0};

	always #50 core_clk = ~core_clk;

	dpl_link_if link_if_inst (.core_clk(core_clk));
	dpl_manager #(.REFRESH_CYCLES(REFRESH)) dpl_manager_inst (.core_clk, .reset_n,
		.link(link_if_inst), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	dpl_regulator dpl_regulator_inst (.core_clk, .reset_n, .link(link_if_inst), .adc_vout,
		.adc_iout, .adc_temp, .pwm_duty, .system_identification_active);
	dpl_link_sva #(.REFRESH_CYCLES(REFRESH)) dpl_link_sva_inst (.core_clk, .reset_n,
		.sw_tick(link_if_inst.sw_tick), .cfg_valid(link_if_inst.cfg_valid),
		.cfg_write(link_if_inst.cfg_write), .cfg_addr(link_if_inst.cfg_addr),
		.cfg_rvalid(link_if_inst.cfg_rvalid), .cfg_rdata(link_if_inst.cfg_rdata),
		.share_out(link_if_inst.share_out), .share_oe(link_if_inst.share_oe),
		.peer_share_low(link_if_inst.peer_share_low));

	// ==========================================================
	// reporting
	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tmo(input bit late);
		if (late) begin
			err_count++;
			$display("Error wait expected answer seen none");
			end_of_test();
		end
	endtask

	// read results are matched against the oldest note
	always @(posedge core_clk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
			sm = q_mask.pop_front();
			check("rdata", q_data.pop_front() & sm, s_axi_rdata & sm);
			check("rresp", {30'h0, q_resp.pop_front()}, {30'h0, s_axi_rresp});
		end
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
			check("bresp", {30'h0, q_bresp.pop_front()}, {30'h0, s_axi_bresp});
	end

	// ==========================================================
	// bus tasks
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		n = 0;
		@(posedge core_clk);
		q_bresp.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1) && n < 200);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		while (s_axi_bvalid !== 1'b1 && n < 200) begin
			@(posedge core_clk);
			n++;
		end
		s_axi_bready <= 1'b0;
		tmo(n >= 200);
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk,
		input logic [1:0] r);
		int n;
		n = 0;
		@(posedge core_clk);
		q_data.push_back(e);
		q_mask.push_back(mk);
		q_resp.push_back(r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (s_axi_arready !== 1'b1 && n < 200);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1 && n < 200) begin
			@(posedge core_clk);
			n++;
		end
		got = s_axi_rdata;
		s_axi_rready <= 1'b0;
		tmo(n >= 200);
	endtask

	// forwards one command and polls until the manager is idle again
	task automatic reg_cmd(input logic [31:0] c);
		int k;
		k = 0;
		axi_wr(8'h00, c, 2'b00);
		do begin
			axi_rd(8'h04, 32'h0, 32'h0, 2'b00);
			k++;
		end while (got[16] !== 1'b0 && k < 50);
		tmo(k >= 50);
	endtask

	task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
		reg_cmd({11'h0, a, d});
	endtask

	task automatic reg_rd(input logic [4:0] a, input logic [15:0] e, input logic [15:0] mk);
		reg_cmd({7'h0, 1'b1, 3'h0, a, 16'h0});
		axi_rd(8'h04, {16'h0, e}, {15'h0, 1'b1, mk}, 2'b00);
	endtask

	task automatic tel(input logic [7:0] t, input logic [7:0] i, input logic [7:0] ei);
		adc_vout <= 12'($random(seed));
		adc_temp <= t;
		adc_iout <= i;
		repeat (2 * REFRESH + 40) @(posedge core_clk);
		axi_rd(8'h08, {20'h0, adc_vout}, 32'hfff, 2'b00);
		axi_rd(8'h0c, {24'h0, ei}, 32'hff, 2'b00);
		axi_rd(8'h10, {24'h0, t}, 32'hff, 2'b00);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		link_if_inst.peer_share_low = 1'b0;
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 8; i++) reg_rd(5'(i), rst_tab[i], 16'hffff);
		for (int i = 1; i < 5; i++) begin
			m = $random(seed);
			reg_wr(5'(i), m[15:0]);
			reg_rd(5'(i), m[15:0], (i == 4) ? 16'h000f : 16'h00ff);
			reg_wr(5'(i), rst_tab[i]);
		end
		lim = 8'h08 + {2'b00, 6'($random(seed))};
		reg_wr(5'h00, {8'h00, lim});
		reg_wr(5'h06, 16'h0fff);
		adc_vout <= 12'h000;
		repeat (80) @(posedge core_clk);
		check("pwm_duty", {24'h0, lim}, {24'h0, pwm_duty});
		adc_vout <= 12'h7ff & 12'($random(seed));
		reg_wr(5'h07, 16'h0001);
		repeat (200) @(posedge core_clk);
		check("system_identification_active", 32'h1, {31'h0, system_identification_active});
		check("pwm_duty", {24'h0, lim}, {24'h0, pwm_duty});
		reg_rd(5'h10, {4'h0, adc_vout}, 16'h7fff);
		reg_wr(5'h07, 16'h0000);
		m = $random(seed);
		tel(8'h40, m[7:0], m[7:0]);
		tel(8'h80, 8'h80, 8'h60);
		axi_wr(8'h14, 32'h9, 2'b00);
		axi_wr(8'h14, 32'ha, 2'b00);
		axi_rd(8'h14, 32'h9, 32'hf, 2'b00);
		axi_wr(8'h18, 32'h1, 2'b10);
		axi_rd(8'h18, 32'h0, 32'hffffffff, 2'b10);
		adc_temp <= 8'h40;
		adc_iout <= 8'h40;
		link_if_inst.peer_share_low <= 1'b1;
		repeat (800) @(posedge core_clk);
		reg_rd(5'h0b, 16'h001f, 16'h003f);
		link_if_inst.peer_share_low <= 1'b0;
		// own low = (iout * 20) >> 8 less regulation
		for (int j = 0; j < 3; j++) begin
			reg_wr(5'h05, (j == 0) ? 16'h0 : (j == 1) ? 16'h2 : 16'hf);
			repeat (60) @(posedge core_clk);
			cnt = 0;
			repeat (20) begin
				@(posedge core_clk);
				cnt += (link_if_inst.share_oe === 1'b1);
			end
			check("share low", (j == 0) ? 5 : (j == 1) ? 3 : 0, cnt);
		end
		end_of_test();
	end
endmodule

`default_nettype wire
